// *** rtl/usar_cfg.svh ***
// Register map, field positions and reset values for the UART status/aux block.
// Included by the top module and by the bench host and test files; definitions only.
`ifndef USAR_CFG_SVH
`define USAR_CFG_SVH
`define USAR_OFF_DIV_LOW 4'h0
`define USAR_OFF_DIV_HIGH 4'h1
`define USAR_OFF_INT_ENABLE 4'h2
`define USAR_OFF_LINE_CTRL 4'h3
`define USAR_OFF_MODEM_CTRL 4'h4
`define USAR_OFF_LINE_STATUS 4'h5
`define USAR_OFF_MODEM_STATUS 4'h6
`define USAR_OFF_SCRATCH 4'h7
`define USAR_OFF_FEATURE 4'h8
`define USAR_OFF_ENH_FEATURE 4'h9
`define USAR_OFF_DEV_ID 4'hA
`define USAR_OFF_DEV_REV 4'hB
`define USAR_OFF_TRIGGER 4'hC
`define USAR_OFF_FIFO_COUNT 4'hD
`define USAR_OFF_RX_TRIG_RD 4'hE
`define USAR_OFF_TX_TRIG_RD 4'hF
`define USAR_SCRATCH_RST 8'hFF
`define USAR_ZERO_BYTE 8'h00
`define USAR_LCR_ENH_KEY 8'hBF
// Arbitrary identity value, not that of any real part
`define USAR_DEV_ID_VAL 8'h5A
// Arbitrary revision value
`define USAR_DEV_REV_VAL 8'h03
`define USAR_IER_MODEM_BIT 3
`define USAR_MCR_RTS_BIT 1
`define USAR_MCR_DTR_BIT 0
`define USAR_MCR_OUT1_BIT 2
`define USAR_MCR_OUT2_BIT 3
`define USAR_MCR_LOOP_BIT 4
`define USAR_FEATURE_CONTROL_SWAP_BIT 6
`define USAR_FEATURE_CONTROL_TRGSEL_BIT 7
`define USAR_EFR_AUTOCTS_BIT 7
`define USAR_LSR_THRE_BIT 5
`define USAR_LSR_TEMT_BIT 6
`define USAR_LSR_FERR_BIT 7
`endif

// *** rtl/usar_pkg.sv ***
// Types shared by the UART status/aux block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package usar_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } usar_bus_req_t;
    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic ri_n;
        logic cd_n;
    } usar_modem_in_t;
    typedef struct packed {
        logic fifo_mode;
        logic thr_loaded;
        logic thr_to_shift;
        logic shift_busy;
        logic char_done;
        logic rx_err_present;
        logic [7:0] tx_count;
        logic [7:0] rx_count;
    } usar_core_stat_t;
    typedef enum logic [1:0] {
        USAR_FL_RX = 2'b00,
        USAR_FL_TX = 2'b01,
        USAR_FL_RX2 = 2'b10,
        USAR_FL_ALT = 2'b11
    } usar_fifo_level_readback_mode_t;
    typedef enum logic [1:0] {
        USAR_TX_RUN = 2'b00,
        USAR_TX_DRAIN = 2'b01,
        USAR_TX_HOLD = 2'b11
    } usar_tx_gate_t;
endpackage

// *** rtl/usar_status_aux.sv ***
// Status and auxiliary register logic of one UART channel.
// Assumes a host on a simple strobe port and a core that reports FIFO and shifter state.
//
// Operation
// RULE1: Non-FIFO: holding-empty sets on transfer to shifter, clears on host load.
// RULE2: FIFO mode: holding-empty equals transmit FIFO count zero.
// RULE3: Transmitter-empty reads 1 only when holding, FIFO and shifter are empty.
// RULE4: Receive error flag follows any tagged byte still in receive FIFO.
// RULE5: CTS, DSR, CD change flags set on any level change of input.
// RULE6: Ring change flag sets only on ring input rising edge.
// RULE7: Any change flag with modem interrupt enable raises modem interrupt.
// RULE8: Auto-CTS high stops transmitter after current character; low resumes.
// RULE9: Outside loopback, status bits 7:4 are inverted CTS, DSR, RI, CD pins; the code puts CD in bit 7, RI in 6, DSR in 5, CTS in 4.
// RULE10: Loopback: bits 4..7 mirror RTS, DTR, control bit 2, control bit 3.
// RULE11: Scratch store is 8-bit read/write, reset to FF.
// RULE12: Swap bit set: scratch writes go to mode select, reads give level.
// RULE13: Mode select low bits pick rx, tx, rx or alternating level readback.
// RULE14: Alternating mode: first read after mode write gives rx, then alternate.
// RULE15: Hysteresis from extended pair then basic pair via fixed table.
// RULE16: Divisor high and low bytes form 16-bit divisor for baud generator.
// RULE17: Host zeroes both divisor bytes before reading identity or revision.
// RULE18: Trigger write loads rx level when select bit 0, tx level when 1.
// RULE19: FIFO data count reachable only while line control holds BF.
// RULE20: FIFO data count gives tx count when select bit 1, else rx count.
// RULE21: Loopback: control bit 3 set drives internal second output low.
// RULE22: Reading modem status clears all four change flags.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "usar_cfg.svh"
module usar_status_aux (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire usar_pkg::usar_bus_req_t bus_in,
    output logic [7:0] rdata_out,
    input wire usar_pkg::usar_modem_in_t modem_in,
    input wire usar_pkg::usar_core_stat_t core_in,
    output logic modem_irq_out,
    output logic tx_enable_out,
    output logic [15:0] divisor_out,
    output logic [5:0] rts_hyst_out,
    output logic [7:0] rx_trigger_out,
    output logic [7:0] tx_trigger_out,
    output logic rts_n_out,
    output logic dtr_n_out,
    output logic loopback_out,
    output logic second_out_n_out
);
    import usar_pkg::*;

    logic rst_sync1;
    logic rstn;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync1 <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rstn <= rst_sync1;
        end
    end

    // Software registers
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] int_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] scratch_store;
    logic [7:0] feature_control;
    logic [7:0] enhanced_feature;
    logic [7:0] enhanced_mode_select;
    logic [7:0] rx_trig;
    logic [7:0] tx_trig;
    logic [3:0] delta;
    logic [3:0] modem_prev;
    logic thre_nf;
    logic alt_tx_next;
    usar_tx_gate_t tx_gate;

    wire [3:0] a = bus_in.addr;
    wire wr = bus_in.wr;
    wire rd = bus_in.rd;
    wire [7:0] wd = bus_in.wdata;
    wire loop = modem_control[`USAR_MCR_LOOP_BIT];
    wire swap = feature_control[`USAR_FEATURE_CONTROL_SWAP_BIT];
    wire trg_sel = feature_control[`USAR_FEATURE_CONTROL_TRGSEL_BIT];
    wire enh_key = (line_control == `USAR_LCR_ENH_KEY);

    wire wr_div_low = wr && a == `USAR_OFF_DIV_LOW;
    wire wr_div_high = wr && a == `USAR_OFF_DIV_HIGH;
    wire wr_ier = wr && a == `USAR_OFF_INT_ENABLE;
    wire wr_lcr = wr && a == `USAR_OFF_LINE_CTRL;
    wire wr_mcr = wr && a == `USAR_OFF_MODEM_CTRL;
    wire wr_feature_control = wr && a == `USAR_OFF_FEATURE;
    wire wr_efr = wr && a == `USAR_OFF_ENH_FEATURE;
    // RULE12 swap steers writes
    wire wr_scr = wr && a == `USAR_OFF_SCRATCH && !swap;
    wire wr_enhanced_mode_select = wr && a == `USAR_OFF_SCRATCH && swap;
    // RULE18 trigger target
    wire wr_rx_trg = wr && a == `USAR_OFF_TRIGGER && !trg_sel;
    wire wr_tx_trg = wr && a == `USAR_OFF_TRIGGER && trg_sel;
    wire rd_msr = rd && a == `USAR_OFF_MODEM_STATUS;
    wire rd_fifo_level_readback = rd && a == `USAR_OFF_SCRATCH && swap;

    // RULE9 inverted pins / RULE10 loopback mirror / RULE21 second output
    wire [3:0] live_in = ~{modem_in.cd_n, modem_in.ri_n, modem_in.dsr_n, modem_in.cts_n};
    wire [3:0] loop_in = {modem_control[`USAR_MCR_OUT2_BIT], modem_control[`USAR_MCR_OUT1_BIT],
                          modem_control[`USAR_MCR_DTR_BIT], modem_control[`USAR_MCR_RTS_BIT]};
    wire [3:0] modem_now = loop ? loop_in : live_in;

    // RULE5 any level change / RULE6 ring end only (ri status falling = pin rising)
    wire [3:0] change = modem_now ^ modem_prev;
    wire [3:0] delta_evt = {change[3], change[2] & modem_prev[2], change[1], change[0]};
    // RULE22 read clears, a new event wins
    wire [3:0] next_delta = delta_evt | (rd_msr ? 4'h0 : delta);
    wire [7:0] modem_status = {modem_now, delta};

    // RULE1 non-FIFO holding-empty
    wire next_thre_nf = core_in.thr_to_shift ? 1'b1 : (core_in.thr_loaded ? 1'b0 : thre_nf);
    // RULE2 FIFO holding-empty
    wire thre = core_in.fifo_mode ? (core_in.tx_count == `USAR_ZERO_BYTE) : thre_nf;
    // RULE3 transmitter idle
    wire temt = thre && !core_in.shift_busy;
    // RULE4 receive error summary
    wire [7:0] line_status = {core_in.rx_err_present, temt, thre, 5'h00};

    // RULE13 level readback mode / RULE14 alternation
    usar_fifo_level_readback_mode_t fl_mode;
    assign fl_mode = usar_fifo_level_readback_mode_t'(enhanced_mode_select[1:0]);
    wire fl_tx = (fl_mode == USAR_FL_TX) || (fl_mode == USAR_FL_ALT && alt_tx_next);
    wire [7:0] fifo_level = fl_tx ? core_in.tx_count : core_in.rx_count;
    wire next_alt = wr_enhanced_mode_select ? 1'b0 : ((rd_fifo_level_readback && fl_mode == USAR_FL_ALT) ? !alt_tx_next
                                                                        : alt_tx_next);
    // RULE20 data count source
    wire [7:0] fifo_data_count = trg_sel ? core_in.tx_count : core_in.rx_count;

    // RULE15 hysteresis table
    logic [5:0] hyst;
    always_comb begin
        case ({enhanced_mode_select[5:4], feature_control[1:0]})
            4'h0: hyst = 6'd0;
            4'h1: hyst = 6'd4;
            4'h2: hyst = 6'd6;
            4'h3: hyst = 6'd8;
            4'h4: hyst = 6'd8;
            4'h5: hyst = 6'd16;
            4'h6: hyst = 6'd24;
            4'h7: hyst = 6'd32;
            4'h8: hyst = 6'd40;
            4'h9: hyst = 6'd44;
            4'hA: hyst = 6'd48;
            4'hB: hyst = 6'd52;
            4'hC: hyst = 6'd12;
            4'hD: hyst = 6'd20;
            4'hE: hyst = 6'd28;
            4'hF: hyst = 6'd36;
            default: hyst = 6'd0;
        endcase
    end

    // Read mux; unmapped or keyed-off locations read zero
    logic [7:0] rmux;
    always_comb begin
        case (a)
            `USAR_OFF_DIV_LOW: rmux = div_low;
            `USAR_OFF_DIV_HIGH: rmux = div_high;
            `USAR_OFF_INT_ENABLE: rmux = int_enable;
            `USAR_OFF_LINE_CTRL: rmux = line_control;
            `USAR_OFF_MODEM_CTRL: rmux = modem_control;
            `USAR_OFF_LINE_STATUS: rmux = line_status;
            `USAR_OFF_MODEM_STATUS: rmux = modem_status;
            // RULE12 level replaces scratch on read
            `USAR_OFF_SCRATCH: rmux = swap ? fifo_level : scratch_store;
            `USAR_OFF_FEATURE: rmux = feature_control;
            `USAR_OFF_ENH_FEATURE: rmux = enhanced_feature;
            // RULE17 identity is fixed; the host zeroes divisors first
            `USAR_OFF_DEV_ID: rmux = `USAR_DEV_ID_VAL;
            `USAR_OFF_DEV_REV: rmux = `USAR_DEV_REV_VAL;
            // RULE19 count visible only under key
            `USAR_OFF_FIFO_COUNT: rmux = enh_key ? fifo_data_count : `USAR_ZERO_BYTE;
            `USAR_OFF_RX_TRIG_RD: rmux = rx_trig;
            `USAR_OFF_TX_TRIG_RD: rmux = tx_trig;
            default: rmux = `USAR_ZERO_BYTE;
        endcase
    end

    // RULE8 auto-CTS gate; stop only at a character boundary
    wire cts_block = enhanced_feature[`USAR_EFR_AUTOCTS_BIT] && !modem_now[0];
    usar_tx_gate_t next_tx_gate;
    always_comb begin
        case (tx_gate)
            USAR_TX_RUN: next_tx_gate = cts_block ?
                (core_in.shift_busy ? USAR_TX_DRAIN : USAR_TX_HOLD) : USAR_TX_RUN;
            USAR_TX_DRAIN: next_tx_gate = !cts_block ? USAR_TX_RUN :
                (core_in.char_done ? USAR_TX_HOLD : USAR_TX_DRAIN);
            USAR_TX_HOLD: next_tx_gate = cts_block ? USAR_TX_HOLD : USAR_TX_RUN;
            default: next_tx_gate = USAR_TX_RUN;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            div_low <= 8'h00;
            div_high <= 8'h00;
            int_enable <= 8'h00;
            line_control <= 8'h00;
            modem_control <= 8'h00;
            scratch_store <= `USAR_SCRATCH_RST;
            feature_control <= 8'h00;
            enhanced_feature <= 8'h00;
            enhanced_mode_select <= 8'h00;
            rx_trig <= 8'h00;
            tx_trig <= 8'h00;
        end else begin
            if (wr_div_low) div_low <= wd;
            if (wr_div_high) div_high <= wd;
            if (wr_ier) int_enable <= wd;
            if (wr_lcr) line_control <= wd;
            if (wr_mcr) modem_control <= wd;
            // RULE11 scratch store
            if (wr_scr) scratch_store <= wd;
            if (wr_feature_control) feature_control <= wd;
            if (wr_efr) enhanced_feature <= wd;
            // RULE13 reserved bits held zero
            if (wr_enhanced_mode_select) enhanced_mode_select <= {2'h0, wd[5:4], 2'h0, wd[1:0]};
            if (wr_rx_trg) rx_trig <= wd;
            if (wr_tx_trg) tx_trig <= wd;
        end
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            modem_prev <= 4'h0;
            delta <= 4'h0;
            thre_nf <= 1'b1;
            alt_tx_next <= 1'b0;
            tx_gate <= USAR_TX_RUN;
        end else begin
            modem_prev <= modem_now;
            delta <= next_delta;
            thre_nf <= next_thre_nf;
            alt_tx_next <= next_alt;
            tx_gate <= next_tx_gate;
        end
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            rdata_out <= 8'h00;
            modem_irq_out <= 1'b0;
            tx_enable_out <= 1'b1;
            divisor_out <= 16'h0000;
            rts_hyst_out <= 6'h00;
            rx_trigger_out <= 8'h00;
            tx_trigger_out <= 8'h00;
            rts_n_out <= 1'b1;
            dtr_n_out <= 1'b1;
            loopback_out <= 1'b0;
            second_out_n_out <= 1'b1;
        end else begin
            rdata_out <= rd ? rmux : 8'h00;
            // RULE7 modem interrupt
            modem_irq_out <= (|next_delta) && int_enable[`USAR_IER_MODEM_BIT];
            tx_enable_out <= (next_tx_gate != USAR_TX_HOLD);
            // RULE16 16-bit divisor
            divisor_out <= {div_high, div_low};
            rts_hyst_out <= hyst;
            rx_trigger_out <= rx_trig;
            tx_trigger_out <= tx_trig;
            // Loopback keeps the pins idle so the far end sees no toggles
            rts_n_out <= loop ? 1'b1 : !modem_control[`USAR_MCR_RTS_BIT];
            dtr_n_out <= loop ? 1'b1 : !modem_control[`USAR_MCR_DTR_BIT];
            loopback_out <= loop;
            // RULE21 internal second output
            second_out_n_out <= !(loop && modem_control[`USAR_MCR_OUT2_BIT]);
        end
    end
endmodule
`default_nettype wire

// *** tb/usar_props.sv ***
// Port-level checker for the UART status/aux block, bound to its top module.
// Assumes the host keeps the one-cycle strobe rules of the register port.
`timescale 1ns/10ps
`default_nettype none
module usar_props (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire usar_pkg::usar_bus_req_t bus_in,
    input wire logic [7:0] rdata_out,
    input wire logic modem_irq_out,
    input wire usar_pkg::usar_modem_in_t modem_in,
    input wire logic tx_enable_out,
    input wire logic [15:0] divisor_out,
    input wire logic [5:0] rts_hyst_out,
    input wire logic [7:0] rx_trigger_out,
    input wire logic [7:0] tx_trigger_out,
    input wire logic rts_n_out,
    input wire logic dtr_n_out,
    input wire logic loopback_out,
    input wire logic second_out_n_out
);
    import usar_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    property p_rd_quiet;
        !$past(bus_in.rd) |-> rdata_out == 8'h00;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data off cycle");
    property p_div_lo;
        bus_in.wr && bus_in.addr == 4'h0 |-> ##2 divisor_out[7:0] == $past(bus_in.wdata, 2);
    endproperty
    a_div_lo: assert property (p_div_lo) else $error("divisor low byte");
    property p_div_hi;
        bus_in.wr && bus_in.addr == 4'h1 |-> ##2 divisor_out[15:8] == $past(bus_in.wdata, 2);
    endproperty
    a_div_hi: assert property (p_div_hi) else $error("divisor high byte");
    property p_trig;
        bus_in.wr && bus_in.addr == 4'hC |-> ##2
            rx_trigger_out == $past(bus_in.wdata, 2) || tx_trigger_out == $past(bus_in.wdata, 2);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger level not loaded");
    property p_hyst;
        rts_hyst_out inside {6'h00, 6'h04, 6'h06, 6'h08, 6'h10, 6'h18, 6'h20, 6'h28,
            6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24};
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis off table");
    property p_second;
        !second_out_n_out |-> loopback_out;
    endproperty
    a_second: assert property (p_second) else $error("second output outside loopback");
    property p_loop_idle;
        loopback_out |-> rts_n_out && dtr_n_out;
    endproperty
    a_loop_idle: assert property (p_loop_idle) else $error("pins driven in loopback");
    // Low clear-to-send must reopen the gate within three cycles
    property p_cts_resume;
        !modem_in.cts_n [*4] |-> tx_enable_out;
    endproperty
    a_cts_resume: assert property (p_cts_resume) else $error("gate stuck closed");
    property p_cts_stop;
        $fell(tx_enable_out) |-> $past(modem_in.cts_n) || $past(modem_in.cts_n, 2);
    endproperty
    a_cts_stop: assert property (p_cts_stop) else $error("gate closed without cts");
    c_gate: cover property ($fell(tx_enable_out));
    c_irq: cover property ($rose(modem_irq_out));
    c_ms_rd: cover property (bus_in.rd && bus_in.addr == 4'h6);
endmodule
bind usar_status_aux usar_props u_props (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .bus_in(bus_in),
    .rdata_out(rdata_out),
    .modem_irq_out(modem_irq_out),
    .modem_in(modem_in),
    .tx_enable_out(tx_enable_out),
    .divisor_out(divisor_out),
    .rts_hyst_out(rts_hyst_out),
    .rx_trigger_out(rx_trigger_out),
    .tx_trigger_out(tx_trigger_out),
    .rts_n_out(rts_n_out),
    .dtr_n_out(dtr_n_out),
    .loopback_out(loopback_out),
    .second_out_n_out(second_out_n_out)
);
`default_nettype wire

// *** tb/usar_host.sv ***
// Host processor model on the strobe register port.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
`include "usar_cfg.svh"
module usar_host (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output var usar_pkg::usar_bus_req_t bus_out
);
    import usar_pkg::*;
    initial bus_out = '0;
    // Released address and data are scrambled so nothing leans on stale values
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_out <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        #1 d = rdata_in;
    endtask
    task automatic id_rd(input logic [3:0] a, output logic [7:0] d);
        wr(`USAR_OFF_DIV_LOW, 8'h00);
        wr(`USAR_OFF_DIV_HIGH, 8'h00);
        rd(a, d);
    endtask
endmodule
`default_nettype wire

// *** tb/uart_status_aux_registers_test.sv ***
// Self-checking bench for the UART status/aux block.
// Assumes the host model drives the register port; modem and core lines come from here.
`timescale 1ns/10ps
`default_nettype none
`include "usar_cfg.svh"
module uart_status_aux_registers_test;
    import usar_pkg::*;
    localparam logic [3:0] sp = `USAR_OFF_SCRATCH;
    localparam logic [3:0] ms = `USAR_OFF_MODEM_STATUS;
    localparam logic [3:0] ls = `USAR_OFF_LINE_STATUS;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    usar_bus_req_t bus;
    usar_modem_in_t modem = 4'hF;
    usar_core_stat_t core = '0;
    logic [7:0] rdata, rv, sc, rx_trg, tx_trg;
    logic [3:0] mo, mn, dl;
    logic irq, tx_en, rts_n, dtr_n, loop, so_n;
    logic [15:0] div;
    logic [5:0] hyst;
    int n_mismatch = 0;
    int n_checks = 0;
    int seed = 91432;
    int hyst_tab[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
    int q[$];
    int i, m, h, f, p;
    always #5 clk_in = ~clk_in;
    usar_host host (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));
    usar_status_aux dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata),
        .modem_in(modem), .core_in(core), .modem_irq_out(irq), .tx_enable_out(tx_en),
        .divisor_out(div), .rts_hyst_out(hyst), .rx_trigger_out(rx_trg),
        .tx_trigger_out(tx_trg), .rts_n_out(rts_n), .dtr_n_out(dtr_n),
        .loopback_out(loop), .second_out_n_out(so_n)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rc(sp, 8'hFF);
        rc(ls, 8'h60);
        host.id_rd(`USAR_OFF_DEV_ID, rv);
        chk(rv, `USAR_DEV_ID_VAL);
        host.id_rd(`USAR_OFF_DEV_REV, rv);
        chk(rv, `USAR_DEV_REV_VAL);
        for (i = 0; i < 4; i++) begin
            p = $random(seed);
            host.wr(sp, p[7:0]);
            rc(sp, p[7:0]);
        end
        sc = p[7:0];
        host.wr(`USAR_OFF_DIV_LOW, p[15:8]);
        host.wr(`USAR_OFF_DIV_HIGH, p[23:16]);
        // Divisor output lags the register by one clock
        @(posedge clk_in);
        #1 chk(div, p[23:8]);
        $display("test registers done");
        host.wr(`USAR_OFF_INT_ENABLE, 8'h08);
        host.rd(ms, rv);
        for (i = 0; i < 8; i++) begin
            mo = modem;
            mn = 4'($random(seed));
            @(posedge clk_in);
            modem <= mn;
            repeat (3) @(posedge clk_in);
            dl = {mo[0] ^ mn[0], ~mo[1] & mn[1], mo[2] ^ mn[2], mo[3] ^ mn[3]};
            #1 chk(irq, |dl);
            rc(ms, {~mn[0], ~mn[1], ~mn[2], ~mn[3], dl});
            rc(ms, {~mn[0], ~mn[1], ~mn[2], ~mn[3], 4'h0});
            chk(irq, 1'b0);
        end
        for (i = 0; i < 4; i++) begin
            p = $random(seed);
            host.wr(`USAR_OFF_MODEM_CTRL, {4'h1, p[3:0]});
            @(posedge clk_in);
            #1 chk(so_n, !p[3]);
            chk({loop, rts_n, dtr_n}, 3'b111);
            host.rd(ms, rv);
            chk(rv[7:4], {p[3], p[2], p[0], p[1]});
        end
        host.wr(`USAR_OFF_MODEM_CTRL, 8'h03);
        @(posedge clk_in);
        #1 chk({loop, rts_n, dtr_n}, 3'b000);
        host.wr(`USAR_OFF_MODEM_CTRL, 8'h00);
        $display("test modem done");
        @(posedge clk_in);
        core.rx_count <= 8'h21;
        core.tx_count <= 8'h05;
        for (h = 0; h < 4; h++) begin
            for (f = 0; f < 4; f++) begin
                host.wr(`USAR_OFF_FEATURE, 8'h40 | f[7:0]);
                host.wr(sp, 8'(h * 16 + f));
                @(posedge clk_in);
                #1 chk(hyst, hyst_tab[h * 4 + f]);
                for (m = 0; m < 3; m++) begin
                    q.push_back((f == 1 || (f == 3 && m == 1)) ? 5 : 33);
                end
                while (q.size() > 0) begin
                    rc(sp, 8'(q.pop_front()));
                end
            end
        end
        host.wr(`USAR_OFF_FEATURE, 8'h00);
        rc(sp, sc);
        for (i = 0; i < 2; i++) begin
            p = $random(seed);
            host.wr(`USAR_OFF_FEATURE, {i[0], 7'h00});
            host.wr(`USAR_OFF_TRIGGER, p[7:0]);
            @(posedge clk_in);
            #1 chk(i ? tx_trg : rx_trg, p[7:0]);
            rc(i ? `USAR_OFF_TX_TRIG_RD : `USAR_OFF_RX_TRIG_RD, p[7:0]);
        end
        rc(`USAR_OFF_FIFO_COUNT, 8'h00);
        host.wr(`USAR_OFF_LINE_CTRL, 8'hBF);
        rc(`USAR_OFF_FIFO_COUNT, 8'h05);
        host.wr(`USAR_OFF_FEATURE, 8'h00);
        rc(`USAR_OFF_FIFO_COUNT, 8'h21);
        host.wr(`USAR_OFF_LINE_CTRL, 8'h03);
        $display("test fifo level done");
        @(posedge clk_in);
        core.fifo_mode <= 1'b1;
        rc(ls, 8'h00);
        core.tx_count <= 8'h00;
        core.shift_busy <= 1'b1;
        rc(ls, 8'h20);
        core.shift_busy <= 1'b0;
        core.rx_err_present <= 1'b1;
        rc(ls, 8'hE0);
        core.rx_err_present <= 1'b0;
        core.fifo_mode <= 1'b0;
        core.thr_loaded <= 1'b1;
        @(posedge clk_in);
        core.thr_loaded <= 1'b0;
        rc(ls, 8'h00);
        core.thr_to_shift <= 1'b1;
        core.shift_busy <= 1'b1;
        @(posedge clk_in);
        core.thr_to_shift <= 1'b0;
        rc(ls, 8'h20);
        $display("test line status done");
        host.wr(`USAR_OFF_ENH_FEATURE, 8'h80);
        @(posedge clk_in);
        modem.cts_n <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1 chk(tx_en, 1'b1);
        @(posedge clk_in);
        core.char_done <= 1'b1;
        core.shift_busy <= 1'b0;
        @(posedge clk_in);
        core.char_done <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 chk(tx_en, 1'b0);
        @(posedge clk_in);
        modem.cts_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1 chk(tx_en, 1'b1);
        $display("test auto cts done");
        stop_test();
    end
endmodule
`default_nettype wire
